/* mpc_consts.vh */
/*
 * Register indices, fields, reset values and line codes.
 * Assumes inclusion by bare name.
 */
// Functional notes
// [R1] Local-fault codes acted on only when enabled
// [R2] Fault stops delivery, ends packet with error
// [R3] After fault, wait for start block
// [R4] Pause frames matched by ethertype and opcode
// [R5] Compare destination and source pause addresses
// [R6] Global control: ethertype plus opcode range
// [R7] Priority control: ethertype plus opcode range
// [R8] Acknowledge input used only when checking enabled
// [R9] Control frames forwarded only when enabled
// [R10] Global pause transmit fields are configurable
// [R11] Priority pause transmit fields independently configurable
// [R12] One-step timestamp only when enabled
// [R13] Transparent mode: timer is positive correction
// [R14] Transparent mode overwrites outgoing correction field
// [R15] User timers given in correction format
// [R16] Latency offset: ns bits plus 3 fraction
// [R17] Offset default 705, transparent use 802
// [R18] Integrator holds reserved test settings false
// [R19] One transmit clock for all logic
// [R20] Receive clock equals transmit clock
// [R21] Lane width 32 ten-lane, 80 four-lane; four-lane payload uses only 64 of the 80 bits
// [R22] Configuration-port clock optional, up to 250MHz
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH

// Register word indices; byte address is four times the index
`define MPC_REG_CTRL 5'h00
`define MPC_REG_STATUS 5'h01
`define MPC_REG_GCP_OPS 5'h02
`define MPC_REG_PCP_OPS 5'h03
`define MPC_REG_CTL_ETYPES 5'h04
`define MPC_REG_RX_GPP 5'h05
`define MPC_REG_RX_PPP 5'h06
`define MPC_REG_UCAST_LO 5'h07
`define MPC_REG_UCAST_HI 5'h08
`define MPC_REG_MCAST_LO 5'h09
`define MPC_REG_MCAST_HI 5'h0A
`define MPC_REG_RX_SA_LO 5'h0B
`define MPC_REG_RX_SA_HI 5'h0C
`define MPC_REG_TXG_DA_LO 5'h0D
`define MPC_REG_TXG_DA_HI 5'h0E
`define MPC_REG_TXG_SA_LO 5'h0F
`define MPC_REG_TXG_SA_HI 5'h10
`define MPC_REG_TXG_TYPE 5'h11
`define MPC_REG_TXP_DA_LO 5'h12
`define MPC_REG_TXP_DA_HI 5'h13
`define MPC_REG_TXP_SA_LO 5'h14
`define MPC_REG_TXP_SA_HI 5'h15
`define MPC_REG_TXP_TYPE 5'h16
`define MPC_REG_LAT_ADJ 5'h17
`define MPC_REG_DROP_CNT 5'h18
`define MPC_NUM_CFG 24

// Control register bit positions
`define MPC_CTRL_LF_EN 0
`define MPC_CTRL_CHECK_ACK 1
`define MPC_CTRL_FORWARD 2
`define MPC_CTRL_ONE_STEP 3
`define MPC_CTRL_TC_MODE 4
`define MPC_CTRL_FOUR_LANE 5

// Write masks for reserved bits
`define MPC_MASK_CTRL 32'h0000003F
`define MPC_MASK_HI 32'h0000FFFF
`define MPC_MASK_LAT 32'h000007FF
`define MPC_MASK_FULL 32'hFFFFFFFF

// Reset values
`define MPC_RST_CTRL 32'h00000002
`define MPC_RST_OPS 32'h0FFF0000
`define MPC_RST_ETYPES 32'h88088808
`define MPC_RST_PAUSE_TYPE 32'h88080001
`define MPC_RST_MCAST_LO 32'hC2000001
`define MPC_RST_MCAST_HI 32'h00000180
`define MPC_RST_LAT 32'h000002C1
`define MPC_RST_ZERO 32'h00000000

// Line control codes carried in the low byte of a control word
`define MPC_CODE_START 8'hFB
`define MPC_CODE_TERM 8'hFD
`define MPC_CODE_LF 8'h9C

// Header byte counting
`define MPC_HDR_BYTES 5'h10
`define MPC_STEP_TEN 5'h04
`define MPC_STEP_FOUR 5'h08

// Delay depth, lets the header decide first
`define MPC_DELAY_DEPTH 4
`define MPC_WORD_W 67

`endif

/* mpc_lane_model.sv */
/* Lane model: lane clock and word pins.
   Assumes one task call at a time. */
`timescale 1ns/1ps
module mpc_lane_model (
	output reg lane_receive_clock,
	output reg [79:0] lane_rx_data,
	output reg lane_rx_ctrl
);
	// Clock starts low and stands still between task calls
	initial begin
		lane_receive_clock = 1'b0;
		lane_rx_data = 80'h0;
		lane_rx_ctrl = 1'b0;
	end
	// One word per 160 ns; data and rising edge off system edges, falling edge on a system rising edge
	task word(input logic c, input logic [79:0] d);
		begin
			#7 lane_rx_ctrl = c;
			lane_rx_data = d;
			#80 lane_receive_clock = 1'b1;
			#73 lane_receive_clock = 1'b0;
		end
	endtask
	// Released pins show the inverse
	task release_pins();
		begin
			lane_rx_data = ~lane_rx_data;
			lane_rx_ctrl = ~lane_rx_ctrl;
		end
	endtask
endmodule

/* mpc_mac_config.v */
/*
 * Pause and control frame classifier, local fault,
 * pause header sender and timestamps,
 * set over APB. Assumes one 50 MHz clock;
 * lane pins are synchronised by two flip-flops.
 */
`timescale 1ns/1ps
`include "mpc_consts.vh"
module mpc_mac_config (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire lane_receive_clock,
	input wire [79:0] lane_rx_data,
	input wire lane_rx_ctrl,
	output reg rx_out_valid,
	output reg [63:0] rx_out_data,
	output reg rx_out_sop,
	output reg rx_out_eop,
	output reg rx_out_err,
	output reg rx_local_fault,
	output reg [8:0] rx_pause_req,
	input wire [8:0] rx_pause_ack,
	input wire tx_pause_send_global,
	input wire tx_pause_send_priority,
	output reg tx_pause_valid,
	output reg [31:0] tx_pause_data,
	output reg tx_pause_sop,
	output reg tx_pause_eop,
	input wire tx_ts_req,
	input wire [79:0] tx_timer,
	output reg tx_ts_valid,
	output reg [79:0] tx_ts_value
);
	localparam ST_IDLE = 3'b001;
	localparam ST_FRAME = 3'b010;
	localparam ST_FAULT = 3'b100;

	// Reset value of each configuration word
	function [31:0] cfg_default;
		input [4:0] i;
		begin
			case (i)
				`MPC_REG_CTRL: cfg_default = `MPC_RST_CTRL;
				`MPC_REG_GCP_OPS: cfg_default = `MPC_RST_OPS;
				`MPC_REG_PCP_OPS: cfg_default = `MPC_RST_OPS;
				`MPC_REG_CTL_ETYPES: cfg_default = `MPC_RST_ETYPES;
				`MPC_REG_RX_GPP: cfg_default = `MPC_RST_PAUSE_TYPE;
				`MPC_REG_RX_PPP: cfg_default = `MPC_RST_PAUSE_TYPE;
				`MPC_REG_MCAST_LO: cfg_default = `MPC_RST_MCAST_LO;
				`MPC_REG_MCAST_HI: cfg_default = `MPC_RST_MCAST_HI;
				`MPC_REG_TXG_DA_LO: cfg_default = `MPC_RST_MCAST_LO;
				`MPC_REG_TXG_DA_HI: cfg_default = `MPC_RST_MCAST_HI;
				`MPC_REG_TXG_TYPE: cfg_default = `MPC_RST_PAUSE_TYPE;
				`MPC_REG_TXP_DA_LO: cfg_default = `MPC_RST_MCAST_LO;
				`MPC_REG_TXP_DA_HI: cfg_default = `MPC_RST_MCAST_HI;
				`MPC_REG_TXP_TYPE: cfg_default = `MPC_RST_PAUSE_TYPE;
				`MPC_REG_LAT_ADJ: cfg_default = `MPC_RST_LAT;
				default: cfg_default = `MPC_RST_ZERO;
			endcase
		end
	endfunction

	// Writable bits of each configuration word; status word has none
	function [31:0] cfg_mask;
		input [4:0] i;
		begin
			case (i)
				`MPC_REG_CTRL: cfg_mask = `MPC_MASK_CTRL;
				`MPC_REG_STATUS: cfg_mask = `MPC_RST_ZERO;
				`MPC_REG_UCAST_HI, `MPC_REG_MCAST_HI, `MPC_REG_RX_SA_HI: cfg_mask = `MPC_MASK_HI;
				`MPC_REG_TXG_DA_HI, `MPC_REG_TXG_SA_HI: cfg_mask = `MPC_MASK_HI;
				`MPC_REG_TXP_DA_HI, `MPC_REG_TXP_SA_HI: cfg_mask = `MPC_MASK_HI;
				`MPC_REG_LAT_ADJ: cfg_mask = `MPC_MASK_LAT;
				default: cfg_mask = `MPC_MASK_FULL;
			endcase
		end
	endfunction

	reg [31:0] cfg [0:`MPC_NUM_CFG-1];
	reg [15:0] drop_cnt;
	reg sa_match_last;
	reg [2:0] state;

	// APB decode; unmapped words answer an error
	wire [4:0] idx = paddr[6:2];
	wire mapped = ~paddr[7] & (paddr[1:0] == 2'b00) & (idx <= `MPC_REG_DROP_CNT);
	wire writable = mapped & (idx != `MPC_REG_STATUS) & (idx != `MPC_REG_DROP_CNT);
	wire apb_done = psel & penable & pready;
	wire cfg_wr = apb_done & pwrite & writable;
	wire [31:0] status_word = {19'h0, rx_pause_req, 1'b0, sa_match_last,
		state == ST_FRAME, rx_local_fault};

	// One wait state; read data come with ready
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready) begin
				if (~mapped | pwrite) begin
					prdata <= 32'h00000000;
				end else if (idx == `MPC_REG_STATUS) begin
					prdata <= status_word;
				end else if (idx == `MPC_REG_DROP_CNT) begin
					prdata <= {16'h0000, drop_cnt};
				end else begin
					prdata <= cfg[idx];
				end
			end
		end
	end

	// Config words with reset values and masks
	genvar g;
	generate
		for (g = 0; g < `MPC_NUM_CFG; g = g + 1) begin : cfg_word
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					cfg[g] <= cfg_default(g);
				end else if (cfg_wr && idx == g) begin
					cfg[g] <= pwdata & cfg_mask(g);
				end
			end
		end
	endgenerate

	wire [31:0] ctrl = cfg[`MPC_REG_CTRL];
	wire lf_enable = ctrl[`MPC_CTRL_LF_EN];
	wire check_ack = ctrl[`MPC_CTRL_CHECK_ACK];
	wire forward_ctl = ctrl[`MPC_CTRL_FORWARD];
	wire one_step_en = ctrl[`MPC_CTRL_ONE_STEP];
	wire tc_mode = ctrl[`MPC_CTRL_TC_MODE];
	wire four_lane = ctrl[`MPC_CTRL_FOUR_LANE];
	wire [47:0] ucast = {cfg[`MPC_REG_UCAST_HI][15:0], cfg[`MPC_REG_UCAST_LO]};
	wire [47:0] mcast = {cfg[`MPC_REG_MCAST_HI][15:0], cfg[`MPC_REG_MCAST_LO]};
	wire [47:0] pause_sa = {cfg[`MPC_REG_RX_SA_HI][15:0], cfg[`MPC_REG_RX_SA_LO]};
	wire [10:0] lat_adj = cfg[`MPC_REG_LAT_ADJ][10:0];

	// Lane pins cross into our clock through two flip-flops each
	reg [81:0] lane_meta;
	reg [81:0] lane_sync;
	reg lclk_prev;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			lane_meta <= {82{1'b0}};
			lane_sync <= {82{1'b0}};
			lclk_prev <= 1'b0;
		end else begin
			lane_meta <= {lane_receive_clock, lane_rx_ctrl, lane_rx_data};
			lane_sync <= lane_meta;
			lclk_prev <= lane_sync[81];
		end
	end

	// A word is taken on each rising lane clock edge seen in our domain
	wire strobe = lane_sync[81] & ~lclk_prev;
	wire w_ctrl = lane_sync[80];
	wire [79:0] w_data = lane_sync[79:0];
	wire is_start = w_ctrl & (w_data[7:0] == `MPC_CODE_START);
	wire is_term = w_ctrl & (w_data[7:0] == `MPC_CODE_TERM);
	wire is_lf = w_ctrl & (w_data[7:0] == `MPC_CODE_LF);
	wire lf_hit = lf_enable & is_lf; // R1
	// Ten-lane words carry 32 bits, four-lane words 64 of the 80 lane bits
	wire [63:0] w_payload = four_lane ? w_data[63:0] : {32'h00000000, w_data[31:0]}; // R21

	reg stage_valid;
	reg stage_sop;
	reg [63:0] stage_data;
	reg sop_pending;
	reg [127:0] hdr;
	reg [4:0] hdr_cnt;
	reg drop_flag;
	reg drop_hold;

	// Header accumulates destination, source, ethertype and opcode bytes
	wire [127:0] next_hdr = four_lane ? {hdr[63:0], w_payload} : {hdr[95:0], w_payload[31:0]};
	wire [4:0] next_cnt = hdr_cnt + (four_lane ? `MPC_STEP_FOUR : `MPC_STEP_TEN);
	wire data_word = (state == ST_FRAME) & ~w_ctrl & ~lf_hit;
	wire hdr_done = strobe & data_word & (hdr_cnt < `MPC_HDR_BYTES) & (next_cnt == `MPC_HDR_BYTES);
	wire [47:0] h_da = next_hdr[127:80];
	wire [47:0] h_sa = next_hdr[79:32];
	wire [15:0] h_type = next_hdr[31:16];
	wire [15:0] h_op = next_hdr[15:0];
	wire da_ok = (h_da == mcast) | (h_da == ucast); // R5
	wire gpp_hit = (h_type == cfg[`MPC_REG_RX_GPP][31:16]) & (h_op == cfg[`MPC_REG_RX_GPP][15:0]); // R4
	wire ppp_hit = (h_type == cfg[`MPC_REG_RX_PPP][31:16]) & (h_op == cfg[`MPC_REG_RX_PPP][15:0]); // R4
	wire gcp_hit = (h_type == cfg[`MPC_REG_CTL_ETYPES][15:0])
		& (h_op >= cfg[`MPC_REG_GCP_OPS][15:0]) & (h_op <= cfg[`MPC_REG_GCP_OPS][31:16]); // R6
	wire pcp_hit = (h_type == cfg[`MPC_REG_CTL_ETYPES][31:16])
		& (h_op >= cfg[`MPC_REG_PCP_OPS][15:0]) & (h_op <= cfg[`MPC_REG_PCP_OPS][31:16]); // R7
	wire is_control = gcp_hit | pcp_hit | gpp_hit | ppp_hit;

	// Staging word: end flag known at next word
	reg push;
	reg [`MPC_WORD_W-1:0] push_word;
	always @* begin
		push = 1'b0;
		push_word = {stage_data, stage_sop, 1'b0, 1'b0};
		if (strobe & stage_valid) begin
			if (lf_hit) begin
				push = 1'b1;
				push_word = {stage_data, stage_sop, 1'b1, 1'b1}; // R2
			end else if (state == ST_FRAME & ~w_ctrl) begin
				push = 1'b1;
			end else if (state == ST_FRAME & is_term) begin
				push = 1'b1;
				push_word = {stage_data, stage_sop, 1'b1, 1'b0};
			end
		end
	end

	// Idle waits for start; fault blocks delivery
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			stage_valid <= 1'b0;
			stage_sop <= 1'b0;
			stage_data <= 64'h0000000000000000;
			sop_pending <= 1'b0;
			hdr <= {128{1'b0}};
			hdr_cnt <= 5'h00;
			rx_local_fault <= 1'b0;
		end else if (strobe) begin
			if (lf_hit) begin
				state <= ST_FAULT; // R2
				stage_valid <= 1'b0;
				rx_local_fault <= 1'b1;
			end else begin
				case (state)
					ST_IDLE: begin
						if (is_start) begin
							state <= ST_FRAME; // R3
							sop_pending <= 1'b1;
							hdr_cnt <= 5'h00;
						end
					end
					ST_FRAME: begin
						if (~w_ctrl) begin
							stage_valid <= 1'b1;
							stage_sop <= sop_pending;
							stage_data <= w_payload;
							sop_pending <= 1'b0;
							if (hdr_cnt < `MPC_HDR_BYTES) begin
								hdr <= next_hdr;
								hdr_cnt <= next_cnt;
							end
						end else if (is_term) begin
							state <= ST_IDLE;
							stage_valid <= 1'b0;
						end
					end
					ST_FAULT: begin
						// Fault clears on any other word; a fresh start is still needed
						state <= ST_IDLE; // R3
						rx_local_fault <= 1'b0;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	wire dl_valid;
	wire [`MPC_WORD_W-1:0] dl_word;

	mpc_word_delay #(
		.DEPTH(`MPC_DELAY_DEPTH),
		.W(`MPC_WORD_W)
	) u_delay (
		.clock(clock),
		.rst(rst),
		.shift(strobe),
		.in_valid(push),
		.in_word(push_word),
		.out_valid(dl_valid),
		.out_word(dl_word)
	);

	// Classification while the first word is held
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			drop_flag <= 1'b0;
			sa_match_last <= 1'b0;
			drop_cnt <= 16'h0000;
		end else begin
			if (strobe & is_start & state == ST_IDLE) begin
				drop_flag <= 1'b0;
			end else if (hdr_done) begin
				drop_flag <= is_control & ~forward_ctl; // R9
				if (is_control & ~forward_ctl) begin
					drop_cnt <= drop_cnt + 16'h0001;
				end
				if (da_ok & (gpp_hit | ppp_hit)) begin
					sa_match_last <= (h_sa == pause_sa); // R5
				end
			end
		end
	end

	// Set wins over ack; without checking a pulse
	wire [8:0] pause_set = {9{hdr_done & da_ok}} & {gpp_hit, {8{ppp_hit & ~gpp_hit}}};
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_pause_req <= 9'h000;
		end else if (check_ack) begin
			rx_pause_req <= pause_set | (rx_pause_req & ~rx_pause_ack); // R8
		end else begin
			rx_pause_req <= pause_set; // R8
		end
	end

	// Dropped frames are suppressed from word one
	wire drop_now = dl_word[2] ? drop_flag : drop_hold;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			drop_hold <= 1'b0;
			rx_out_valid <= 1'b0;
			rx_out_data <= 64'h0000000000000000;
			rx_out_sop <= 1'b0;
			rx_out_eop <= 1'b0;
			rx_out_err <= 1'b0;
		end else begin
			if (dl_valid & dl_word[2]) begin
				drop_hold <= drop_flag;
			end
			rx_out_valid <= dl_valid & ~drop_now; // R9
			if (dl_valid) begin
				rx_out_data <= dl_word[66:3];
				rx_out_sop <= dl_word[2];
				rx_out_eop <= dl_word[1];
				rx_out_err <= dl_word[0]; // R2
			end
		end
	end

	// Pause header generator; priority wins if both requests come together
	reg tx_busy;
	reg tx_prio;
	reg [1:0] tx_idx;
	wire [47:0] tx_da = tx_prio ? {cfg[`MPC_REG_TXP_DA_HI][15:0], cfg[`MPC_REG_TXP_DA_LO]}
		: {cfg[`MPC_REG_TXG_DA_HI][15:0], cfg[`MPC_REG_TXG_DA_LO]}; // R10 R11
	wire [47:0] tx_sa = tx_prio ? {cfg[`MPC_REG_TXP_SA_HI][15:0], cfg[`MPC_REG_TXP_SA_LO]}
		: {cfg[`MPC_REG_TXG_SA_HI][15:0], cfg[`MPC_REG_TXG_SA_LO]}; // R10 R11
	wire [31:0] tx_type = tx_prio ? cfg[`MPC_REG_TXP_TYPE] : cfg[`MPC_REG_TXG_TYPE];
	reg [31:0] tx_word;
	always @* begin
		case (tx_idx)
			2'h0: tx_word = tx_da[47:16];
			2'h1: tx_word = {tx_da[15:0], tx_sa[47:32]};
			2'h2: tx_word = tx_sa[31:0];
			default: tx_word = tx_type;
		endcase
	end

	// Requests arriving while a header is going out are ignored
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_busy <= 1'b0;
			tx_prio <= 1'b0;
			tx_idx <= 2'h0;
			tx_pause_valid <= 1'b0;
			tx_pause_data <= 32'h00000000;
			tx_pause_sop <= 1'b0;
			tx_pause_eop <= 1'b0;
		end else begin
			tx_pause_valid <= tx_busy;
			tx_pause_sop <= tx_busy & (tx_idx == 2'h0);
			tx_pause_eop <= tx_busy & (tx_idx == 2'h3);
			tx_pause_data <= tx_busy ? tx_word : 32'h00000000;
			if (tx_busy) begin
				tx_idx <= tx_idx + 2'h1;
				tx_busy <= (tx_idx != 2'h3);
			end else if (tx_pause_send_global | tx_pause_send_priority) begin
				tx_busy <= 1'b1;
				tx_prio <= tx_pause_send_priority;
				tx_idx <= 2'h0;
			end
		end
	end

	// 3 fraction bits vs 16-bit timer fraction: shift 13
	wire [79:0] adj_ext = {56'h00000000000000, lat_adj, 13'h0000}; // R16
	wire [63:0] tc_corr = {1'b0, tx_timer[62:0]} + adj_ext[63:0]; // R13
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_ts_valid <= 1'b0;
			tx_ts_value <= {80{1'b0}};
		end else begin
			tx_ts_valid <= tx_ts_req & (tc_mode | one_step_en); // R12
			if (tx_ts_req & tc_mode) begin
				tx_ts_value <= {16'h0000, tc_corr}; // R14
			end else if (tx_ts_req & one_step_en) begin
				tx_ts_value <= tx_timer + adj_ext; // R12
			end
		end
	end
endmodule

/* mpc_mac_config_asserts.sv */
/* Checks bound to the block's ports.
   Assumes config changes only by APB. */
`timescale 1ns/1ps
module mpc_asserts (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire rx_out_valid,
	input wire rx_local_fault,
	input wire [8:0] rx_pause_req,
	input wire [8:0] rx_pause_ack,
	input wire tx_pause_send_global,
	input wire tx_pause_send_priority,
	input wire tx_pause_valid,
	input wire tx_pause_sop,
	input wire tx_pause_eop,
	input wire tx_ts_req,
	input wire [79:0] tx_timer,
	input wire tx_ts_valid,
	input wire [79:0] tx_ts_value
);
	reg [5:0] ctrl;
	reg [10:0] lat;
	wire wr_done = psel && penable && pready && pwrite;
	wire tx_ask = tx_pause_send_global || tx_pause_send_priority;
	// Shadow of mode and latency words
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl <= 6'h02;
			lat <= 11'h2C1;
		end else if (wr_done && paddr == 8'h00) begin
			ctrl <= pwdata[5:0];
		end else if (wr_done && paddr == 8'h5C) begin
			lat <= pwdata[10:0];
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// APB setup and pause header burst
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_header;
		tx_pause_valid && tx_pause_sop && !tx_pause_eop
		##1 (tx_pause_valid && !tx_pause_sop && !tx_pause_eop) [*2]
		##1 tx_pause_valid && tx_pause_eop;
	endsequence
	a_apb_wait: assert property (s_setup |=> !pready ##1 pready)
		else $error("apb wait");
	a_header_burst: assert property (tx_ask && !tx_pause_valid && !$past(tx_ask) |=>
		!tx_pause_valid ##1 s_header)
		else $error("header burst");
	a_fault_enable: assert property ($rose(rx_local_fault) |-> ctrl[0])
		else $error("fault enable");
	a_fault_quiet: assert property (rx_local_fault && $past(rx_local_fault) &&
		$past(rx_local_fault, 2) |-> !rx_out_valid)
		else $error("fault quiet");
	a_fault_restart: assert property ($fell(rx_local_fault) |-> !rx_out_valid [*8])
		else $error("fault restart");
	a_ack_pulse: assert property (rx_pause_req[8] && !ctrl[1] |=> !rx_pause_req[8])
		else $error("ack pulse");
	a_ack_hold: assert property (rx_pause_req[8] && ctrl[1] && !rx_pause_ack[8] |=>
		rx_pause_req[8])
		else $error("ack hold");
	a_ts_gate: assert property (tx_ts_req |=> tx_ts_valid == (ctrl[3] || ctrl[4]))
		else $error("stamp gate");
	a_ts_correction: assert property (tx_ts_req && ctrl[4] |=>
		tx_ts_value == {16'h0000, {1'b0, $past(tx_timer[62:0])} + ({53'h0, lat} << 13)})
		else $error("correction");
	a_ts_one_step: assert property (tx_ts_req && ctrl[3] && !ctrl[4] |=>
		tx_ts_value == $past(tx_timer) + ({69'h0, lat} << 13))
		else $error("one-step");
endmodule
bind mpc_mac_config mpc_asserts chk_u (.*);

/* mpc_word_delay.v */
/*
 * Receive word delay line.
 * Assumes shift pulses once per line word.
 */
`timescale 1ns/1ps
module mpc_word_delay #(
	parameter DEPTH = 4,
	parameter W = 67
) (
	input wire clock,
	input wire rst,
	input wire shift,
	input wire in_valid,
	input wire [W-1:0] in_word,
	output reg out_valid,
	output reg [W-1:0] out_word
);
	reg [W:0] pipe [0:DEPTH-2];
	genvar g;

	// One register stage per entry; entry 0 takes the incoming word
	generate
		for (g = 0; g < DEPTH - 1; g = g + 1) begin : stage
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					pipe[g] <= {(W+1){1'b0}};
				end else if (shift) begin
					if (g == 0) begin
						pipe[g] <= {in_valid, in_word};
					end else begin
						pipe[g] <= pipe[(g == 0) ? 0 : g - 1];
					end
				end
			end
		end
	endgenerate

	// Read data leave from a register, valid only in the cycle after a shift
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_word <= {W{1'b0}};
		end else begin
			out_valid <= shift & pipe[DEPTH-2][W];
			if (shift) begin
				out_word <= pipe[DEPTH-2][W-1:0];
			end
		end
	end
endmodule

/* test_mac_pause_ptp_config_clocking.sv */
/* Self-checking bench.
   Assumes lane model and checker alongside. */
`timescale 1ns/1ps
`include "mpc_consts.vh"
module test_mac_pause_ptp_config_clocking;
	reg clock, rst, psel, penable, pwrite, tx_pause_send_global, tx_pause_send_priority, tx_ts_req;
	reg [7:0] paddr, b;
	reg [31:0] pwdata, seed, rd, t;
	reg [8:0] rx_pause_ack, pr_seen;
	reg [79:0] tx_timer;
	wire [31:0] prdata, tx_pause_data;
	wire pready, pslverr, lane_receive_clock, lane_rx_ctrl, rx_out_valid, rx_out_sop, rx_out_eop;
	wire rx_out_err, rx_local_fault, tx_pause_valid, tx_pause_sop, tx_pause_eop, tx_ts_valid;
	wire [79:0] lane_rx_data, tx_ts_value;
	wire [63:0] rx_out_data;
	wire [8:0] rx_pause_req;
	reg err, four, lf_seen;
	reg [47:0] da_u, sa, pda[2], psa[2];
	reg [31:0] pto[2];
	reg [127:0] h;
	reg [10:0] lat;
	reg [80:0] e;
	reg [66:0] q[$];
	reg [33:0] tq[$];
	reg [63:0] ex[$];
	integer error_cnt, check_count, cyc, k, j, nw;
	localparam logic [39:0] rst_tab [0:13] = '{{8'h00, 32'h00000002}, {8'h08, 32'h0FFF0000},
		{8'h0C, 32'h0FFF0000}, {8'h10, 32'h88088808}, {8'h14, 32'h88080001},
		{8'h18, 32'h88080001}, {8'h24, 32'hC2000001}, {8'h28, 32'h00000180},
		{8'h34, 32'hC2000001}, {8'h38, 32'h00000180}, {8'h44, 32'h88080001},
		{8'h48, 32'hC2000001}, {8'h58, 32'h88080001}, {8'h5C, 32'h000002C1}};
	mpc_mac_config dut_u (.*);
	mpc_lane_model lm (.lane_receive_clock(lane_receive_clock), .lane_rx_data(lane_rx_data),
		.lane_rx_ctrl(lane_rx_ctrl));
	// System clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Capture outputs
	always @(posedge clock) begin
		if (rx_out_valid === 1'b1) q.push_back({rx_out_err, rx_out_sop, rx_out_eop, rx_out_data});
		if (tx_pause_valid === 1'b1) tq.push_back({tx_pause_sop, tx_pause_eop, tx_pause_data});
		pr_seen <= pr_seen | rx_pause_req;
		lf_seen <= lf_seen | rx_local_fault;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			rnd = seed;
		end
	endfunction
	// Expected {valid, stamp}; m = {transparent, one-step}
	function automatic logic [80:0] ts_exp(input logic [1:0] m, input logic [79:0] v,
		input logic [10:0] a);
		begin
			if (m[1]) ts_exp = {1'b1, 16'h0000, {1'b0, v[62:0]} + ({53'h0, a} << 13)};
			else if (m[0]) ts_exp = {1'b1, v + ({69'h0, a} << 13)};
			else ts_exp = 81'h0;
		end
	endfunction
	task chk(input string nm, input logic [79:0] xp, input logic [79:0] got);
		begin
			check_count = check_count + 1;
			if (got !== xp) begin
				error_cnt = error_cnt + 1;
				$display("BAD %s expected %h seen %h", nm, xp, got);
			end
		end
	endtask
	// APB transfer
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'b1;
			@(posedge clock);
			while (pready !== 1'b1) @(posedge clock);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clock);
		end
	endtask
	// Frame of nw words, word lf a fault code
	task frame(input logic [47:0] da, input logic [31:0] to, input integer lf);
		logic [63:0] w;
		begin
			h = {da, sa, to};
			ex.delete();
			lm.word(1'b1, {72'h0, `MPC_CODE_START});
			for (j = 0; j < nw; j++) begin
				w = {rnd(), rnd()};
				if (four && j < 2) w = h[127 - 64 * j -: 64];
				if (!four) w = {32'h0, (j < 4) ? h[127 - 32 * j -: 32] : w[31:0]};
				if (j == lf) lm.word(1'b1, {72'h0, `MPC_CODE_LF});
				else lm.word(1'b0, {16'h0, four ? w[63:32] : rnd(), w[31:0]});
				if (j != lf) ex.push_back(w);
			end
			lm.word(1'b1, {72'h0, `MPC_CODE_TERM});
			for (j = 0; j < 6; j++) lm.word(1'b0, {16'h0, rnd(), rnd()});
			lm.release_pins();
		end
	endtask
	task chk_rx(input integer n, input logic fe);
		begin
			repeat (10) @(posedge clock);
			chk("rx words", n, q.size());
			for (j = 0; j < n && j < q.size(); j++)
				chk("rx word", {fe && j == n - 1, j == 0, j == n - 1, ex[j]}, q[j]);
			q.delete();
		end
	endtask
	task results();
		begin
			$display("checks %0d mismatches %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		seed = 32'h67FD5CE6;
		{error_cnt, check_count, cyc} = 0;
		{rst, psel, penable, pwrite, paddr, pwdata, rx_pause_ack, tx_timer} = 133'h1 << 132;
		{tx_pause_send_global, tx_pause_send_priority, tx_ts_req, pr_seen, lf_seen} = 0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (k = 0; k < 14; k++) begin
			apb(1'b0, rst_tab[k][39:32], 32'h0);
			chk("reset value", rst_tab[k][31:0], rd);
		end
		apb(1'b0, 8'h64, 32'h0);
		chk("unmapped error", 1'b1, err);
		apb(1'b1, 8'h60, rnd());
		apb(1'b0, 8'h60, 32'h0);
		chk("drop count", 32'h0, rd);
		$display("test registers done");
		// Pause headers
		for (k = 0; k < 2; k++) begin
			t = rnd();
			pda[k] = {t[15:0], rnd()};
			psa[k] = {t[31:16], rnd()};
			pto[k] = rnd();
			b = k ? 8'h48 : 8'h34;
			apb(1'b1, b, pda[k][31:0]);
			apb(1'b1, b + 8'h04, {16'h0000, pda[k][47:32]});
			apb(1'b1, b + 8'h08, psa[k][31:0]);
			apb(1'b1, b + 8'h0C, {16'h0000, psa[k][47:32]});
			apb(1'b1, b + 8'h10, pto[k]);
		end
		for (k = 0; k < 2; k++) begin
			tq.delete();
			if (k) tx_pause_send_priority <= 1'b1;
			else tx_pause_send_global <= 1'b1;
			@(posedge clock);
			tx_pause_send_priority <= 1'b0;
			tx_pause_send_global <= 1'b0;
			repeat (8) @(posedge clock);
			h = {pda[k], psa[k], pto[k]};
			chk("pause words", 4, tq.size());
			for (j = 0; j < 4 && j < tq.size(); j++)
				chk("pause word", {j == 0, j == 3, h[127 - 32 * j -: 32]}, tq[j]);
		end
		$display("test pause transmit done");
		// Stamps per mode
		for (k = 0; k < 4; k++) begin
			t = rnd();
			lat = k[1] ? 11'h322 : t[10:0];
			apb(1'b1, 8'h00, {27'h0, k[1:0], 3'h2});
			apb(1'b1, 8'h5C, {21'h0, lat});
			tx_timer <= {t[31:16], rnd(), rnd()};
			tx_ts_req <= 1'b1;
			@(posedge clock);
			tx_ts_req <= 1'b0;
			@(negedge clock);
			e = ts_exp(k[1:0], tx_timer, lat);
			chk("stamp valid", e[80], tx_ts_valid);
			if (e[80]) chk("stamp value", e[79:0], tx_ts_value);
			@(posedge clock);
		end
		apb(1'b1, 8'h00, 32'h2);
		$display("test stamps done");
		// Receive classes
		t = rnd();
		sa = {t[15:0], rnd()};
		da_u = {t[31:16], rnd()};
		nw = 6;
		four = 1'b0;
		frame(da_u, 32'h08000000, -1);
		chk_rx(6, 1'b0);
		frame(48'h0180C2000001, 32'h88080001, -1);
		chk_rx(0, 1'b0);
		chk("pause held", 9'h100, rx_pause_req);
		rx_pause_ack <= 9'h100;
		repeat (3) @(posedge clock);
		chk("pause cleared", 9'h000, rx_pause_req);
		rx_pause_ack <= 9'h1FF;
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h18, 32'h88080101);
		apb(1'b1, 8'h1C, da_u[31:0]);
		apb(1'b1, 8'h20, {16'h0000, da_u[47:32]});
		pr_seen = 9'h000;
		frame(da_u, 32'h88080101, -1);
		chk_rx(0, 1'b0);
		chk("priority pause", 9'h0FF, pr_seen);
		frame(da_u, 32'h88080500, -1);
		chk_rx(0, 1'b0);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h0C, 32'h0);
		frame(da_u, 32'h88080500, -1);
		chk_rx(6, 1'b0);
		apb(1'b0, 8'h60, 32'h0);
		chk("drop count", 32'h3, rd);
		apb(1'b1, 8'h00, 32'h4);
		frame(48'h0180C2000001, 32'h88080001, -1);
		chk_rx(6, 1'b0);
		$display("test receive classes done");
		// Fault handling
		apb(1'b1, 8'h00, 32'h0);
		frame(da_u, 32'h08000000, 5);
		chk_rx(5, 1'b0);
		chk("fault ignored", 1'b0, lf_seen);
		apb(1'b1, 8'h00, 32'h1);
		frame(da_u, 32'h08000000, 5);
		chk_rx(5, 1'b1);
		chk("fault seen", 1'b1, lf_seen);
		frame(da_u, 32'h08000000, -1);
		chk_rx(6, 1'b0);
		$display("test fault done");
		apb(1'b1, 8'h00, 32'h20);
		four = 1'b1;
		nw = 4;
		frame(da_u, 32'h08000000, -1);
		chk_rx(4, 1'b0);
		$display("test four lane done");
		results();
	end
endmodule
